// *** hdl/i2cram_pkg.sv ***
// constants and types shared by the serial ram slave files
package i2cram_pkg;

  // storage array shape
  localparam int MEM_WORDS   = 256;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 8;

  // write path fifo: {word address, data} per entry
  localparam int FIFO_W      = ADDR_W + DATA_W;
  localparam int FIFO_DEPTH  = 16;

  // bits in one byte on the wire, counted from zero
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;

  // fixed upper slave address bits; arbitrary default value
  localparam logic [3:0] ADDR_UPPER_DEF = 4'h5;

  // reset values
  localparam logic [ADDR_W-1:0] WORD_ADDR_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_RST      = 8'h00;
  localparam logic [3:0]        CNT_RST       = 4'h0;

  // what the byte being received is for
  typedef enum logic [1:0] {
    KIND_ADDR = 2'h0,
    KIND_WORD = 2'h1,
    KIND_DATA = 2'h2
  } i2cram_kind_type;

  // bus state machine, one-hot
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_RX      = 6'h02,
    ST_ACK_OUT = 6'h04,
    ST_TX      = 6'h08,
    ST_TX_ACK  = 6'h10,
    ST_IGNORE  = 6'h20
  } i2cram_state_type;

endpackage : i2cram_pkg

// *** hdl/i2cram_stream_if.sv ***
// valid/ready stream carrier between the slave core and its fifo
`timescale 1ns/1ns
interface i2cram_stream_if #(
  parameter int WIDTH = 16
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo_side (
    input  in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
  modport user_side (
    output in_valid, in_data, out_ready,
    input  in_ready, out_valid, out_data
  );
endinterface : i2cram_stream_if

// *** hdl/i2cram_fifo.sv ***
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module i2cram_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  i2cram_stream_if.fifo_side st
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_mem [DEPTH];
  logic [PW:0]      wr_ptr_reg;
  logic [PW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign st.in_ready  = (wr_ptr_reg[PW-1:0] != rd_ptr_reg[PW-1:0]) ||
                        (wr_ptr_reg[PW] == rd_ptr_reg[PW]);
  assign st.out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign st.out_data  = store_mem[rd_ptr_reg[PW-1:0]];
  assign push         = st.in_valid && st.in_ready;
  assign pop          = st.out_valid && st.out_ready;

  // storage has no reset; only pointers define contents
  always_ff @(posedge clk_sys) begin
    if (push) begin
      store_mem[wr_ptr_reg[PW-1:0]] <= st.in_data;
    end
  end

  // pointers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule : i2cram_fifo

// *** hdl/i2cram_top.sv ***
// two-wire serial slave in front of a 256 x 8 static ram
`timescale 1ns/1ns
module i2cram_top #(
  parameter logic [3:0] ADDR_UPPER = i2cram_pkg::ADDR_UPPER_DEF,
  parameter int         FIFO_DEPTH = i2cram_pkg::FIFO_DEPTH
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic hw_addr_bit_zero,
  input  wire logic hw_addr_bit_one,
  input  wire logic hw_addr_bit_two,
  input  wire logic power_save
);
  localparam int AW = i2cram_pkg::ADDR_W;
  localparam int DW = i2cram_pkg::DATA_W;

  i2cram_pkg::i2cram_state_type state_reg;
  i2cram_pkg::i2cram_kind_type  kind_reg;

  logic [5:0]    pin_sync1_reg;
  logic [5:0]    pin_sync2_reg;
  logic          scl_prev_reg;
  logic          sda_prev_reg;
  logic          scl_s;
  logic          sda_s;
  logic          save_s;
  logic [2:0]    hw_addr_s;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_ev;
  logic          stop_ev;
  logic [3:0]    bit_cnt_reg;
  logic [DW-1:0] rx_shift_reg;
  logic [DW-1:0] tx_shift_reg;
  logic [DW-1:0] tx_buf_reg;
  logic [AW-1:0] word_addr_reg;
  logic          rw_reg;
  logic          master_ack_reg;
  logic          fetch_req_reg;
  logic          sda_oe_reg;
  logic          byte_done;
  logic          addr_match;
  logic          give_ack;
  logic          word_load;
  logic          data_push;
  logic          fetch_set;
  logic          fetch_done;
  logic          drain_take;
  logic [DW-1:0] ram_mem [i2cram_pkg::MEM_WORDS];

  i2cram_stream_if #(.WIDTH(i2cram_pkg::FIFO_W)) wq ();

  i2cram_fifo #(
    .WIDTH (i2cram_pkg::FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .st      (wq.fifo_side)
  );

  // every pin crosses two flops before anything looks at it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync1_reg <= 6'h03;
      pin_sync2_reg <= 6'h03;
      scl_prev_reg  <= 1'b1;
      sda_prev_reg  <= 1'b1;
    end else begin
      pin_sync1_reg <= {power_save, hw_addr_bit_two, hw_addr_bit_one,
                        hw_addr_bit_zero, sda_in, scl_in};
      pin_sync2_reg <= pin_sync1_reg;
      scl_prev_reg  <= pin_sync2_reg[0];
      sda_prev_reg  <= pin_sync2_reg[1];
    end
  end

  assign scl_s     = pin_sync2_reg[0];
  assign sda_s     = pin_sync2_reg[1];
  assign hw_addr_s = pin_sync2_reg[4:2];
  assign save_s    = pin_sync2_reg[5];

  // edges; sda moving under a high scl is a bus condition
  assign scl_rise = scl_s && !scl_prev_reg;
  assign scl_fall = !scl_s && scl_prev_reg;
  assign start_ev = scl_s && scl_prev_reg && !sda_s && sda_prev_reg;
  assign stop_ev  = scl_s && scl_prev_reg && sda_s && !sda_prev_reg;

  // address byte: fixed part, pin levels, direction last
  assign addr_match = (rx_shift_reg[7:1] == {ADDR_UPPER, hw_addr_s});
  assign byte_done  = (state_reg == i2cram_pkg::ST_RX) && scl_fall &&
                      (bit_cnt_reg == i2cram_pkg::BYTE_BITS);
  // full fifo is the one case where an addressed write is refused
  always_comb begin
    case (kind_reg)
      i2cram_pkg::KIND_ADDR: give_ack = addr_match;
      i2cram_pkg::KIND_WORD: give_ack = 1'b1;
      i2cram_pkg::KIND_DATA: give_ack = wq.in_ready;
      default:               give_ack = 1'b0;
    endcase
  end

  assign word_load = byte_done && (kind_reg == i2cram_pkg::KIND_WORD);
  assign data_push = byte_done && (kind_reg == i2cram_pkg::KIND_DATA) &&
                     wq.in_ready;
  assign fetch_set = (byte_done && (kind_reg == i2cram_pkg::KIND_ADDR) &&
                      addr_match && rx_shift_reg[0]) ||
                     ((state_reg == i2cram_pkg::ST_TX_ACK) && scl_rise &&
                      !sda_s);
  // a read waits until queued writes are in the array
  assign fetch_done = fetch_req_reg && !wq.out_valid;
  // draining never waits on a pending fetch, else the two would deadlock
  assign drain_take = wq.out_valid && wq.out_ready;

  assign wq.in_valid  = data_push;
  assign wq.in_data   = {word_addr_reg, rx_shift_reg};
  assign wq.out_ready = !fetch_done;

  // bus state machine; start beats everything but power save
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= i2cram_pkg::ST_IDLE;
      kind_reg       <= i2cram_pkg::KIND_ADDR;
      bit_cnt_reg    <= i2cram_pkg::CNT_RST;
      rx_shift_reg   <= i2cram_pkg::BYTE_RST;
      rw_reg         <= 1'b0;
      master_ack_reg <= 1'b0;
    end else if (save_s) begin
      state_reg <= i2cram_pkg::ST_IDLE;
    end else if (start_ev) begin
      state_reg   <= i2cram_pkg::ST_RX;
      kind_reg    <= i2cram_pkg::KIND_ADDR;
      bit_cnt_reg <= i2cram_pkg::CNT_RST;
    end else if (stop_ev) begin
      state_reg <= i2cram_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        i2cram_pkg::ST_RX: begin
          if (scl_rise) begin
            rx_shift_reg <= {rx_shift_reg[DW-2:0], sda_s};
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_reg <= i2cram_pkg::CNT_RST;
            state_reg   <= give_ack ? i2cram_pkg::ST_ACK_OUT
                                    : i2cram_pkg::ST_IGNORE;
            if (kind_reg == i2cram_pkg::KIND_ADDR) begin
              rw_reg   <= rx_shift_reg[0];
              kind_reg <= i2cram_pkg::KIND_WORD;
            end else begin
              kind_reg <= i2cram_pkg::KIND_DATA;
            end
          end
        end
        i2cram_pkg::ST_ACK_OUT: begin
          if (scl_fall) begin
            state_reg <= rw_reg ? i2cram_pkg::ST_TX
                                : i2cram_pkg::ST_RX;
          end
        end
        i2cram_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == i2cram_pkg::LAST_BIT) begin
              bit_cnt_reg <= i2cram_pkg::CNT_RST;
              state_reg   <= i2cram_pkg::ST_TX_ACK;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        i2cram_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            master_ack_reg <= !sda_s;
          end else if (scl_fall) begin
            state_reg <= master_ack_reg ? i2cram_pkg::ST_TX
                                        : i2cram_pkg::ST_IGNORE;
          end
        end
        i2cram_pkg::ST_IDLE, i2cram_pkg::ST_IGNORE: begin
          state_reg <= state_reg;                         // wait for start
        end
        default: state_reg <= i2cram_pkg::ST_IDLE;
      endcase
    end
  end

  // transmit shifter: load at byte boundary, shift on each scl fall in ST_TX
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift_reg <= i2cram_pkg::BYTE_RST;
    end else if (scl_fall &&
                 (((state_reg == i2cram_pkg::ST_ACK_OUT) && rw_reg) ||
                  ((state_reg == i2cram_pkg::ST_TX_ACK) &&
                   master_ack_reg))) begin
      tx_shift_reg <= tx_buf_reg;
    end else if (scl_fall && (state_reg == i2cram_pkg::ST_TX)) begin
      tx_shift_reg <= {tx_shift_reg[DW-2:0], 1'b1};
    end
  end

  // read fetch request; a new request wins over completion
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fetch_req_reg <= 1'b0;
    end else if (fetch_set) begin
      fetch_req_reg <= 1'b1;
    end else if (fetch_done) begin
      fetch_req_reg <= 1'b0;
    end
  end

  // word address: loaded by a write, stepped after each queued data byte and each read fetch
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      word_addr_reg <= i2cram_pkg::WORD_ADDR_RST;
    end else if (word_load) begin
      word_addr_reg <= rx_shift_reg;
    end else if (data_push || fetch_done) begin
      word_addr_reg <= word_addr_reg + 8'h01;
    end
  end

  // single array port: drain the write queue first, read for the wire once it is empty
  always_ff @(posedge clk_sys) begin
    if (drain_take) begin
      ram_mem[wq.out_data[DW+AW-1:DW]] <= wq.out_data[DW-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_buf_reg <= i2cram_pkg::BYTE_RST;
    end else if (fetch_done) begin
      tx_buf_reg <= ram_mem[word_addr_reg];
    end
  end

  // open drain: pull low for ack or a zero data bit, else release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sda_oe_reg <= 1'b0;
    end else begin
      sda_oe_reg <= (state_reg == i2cram_pkg::ST_ACK_OUT) ||
                    ((state_reg == i2cram_pkg::ST_TX) &&
                     !tx_shift_reg[DW-1]);
    end
  end

  assign sda_oe  = sda_oe_reg;
  assign sda_out = 1'b0;

  a_start_enters_rx : assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (start_ev && !save_s) |=> (state_reg == i2cram_pkg::ST_RX) &&
                              (bit_cnt_reg == 4'h0))
    else $error("start did not open a fresh address byte");

  a_stop_goes_idle : assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (stop_ev && !start_ev) |=> (state_reg == i2cram_pkg::ST_IDLE))
    else $error("stop did not end the transfer");

  a_ack_pulls_low : assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    $rose(state_reg == i2cram_pkg::ST_ACK_OUT) |-> ##1 sda_oe_reg)
    else $error("acknowledge not driven low");

  a_nack_releases : assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (state_reg inside {i2cram_pkg::ST_TX_ACK, i2cram_pkg::ST_IGNORE})
      |=> !sda_oe_reg)
    else $error("sda held while it must be released");

  a_mismatch_ignored : assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (byte_done && kind_reg == i2cram_pkg::KIND_ADDR && !addr_match &&
     !save_s) |=> (state_reg == i2cram_pkg::ST_IGNORE) ##1 !sda_oe_reg)
    else $error("foreign address was answered");

  a_word_addr_load : assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    word_load |=> (word_addr_reg == $past(rx_shift_reg)))
    else $error("word address not loaded from first data byte");

  a_addr_steps_one : assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (data_push || fetch_done) |=>
      (word_addr_reg == 8'($past(word_addr_reg) + 8'h01)))
    else $error("word address did not step by one");

  a_fetch_bounded : assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    $rose(fetch_req_reg) |-> ##[1:3] !fetch_req_reg)
    else $error("read fetch stalled too long");

  a_tx_bit_steady : assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (state_reg == i2cram_pkg::ST_TX && scl_s && scl_prev_reg && !start_ev &&
     !stop_ev && !save_s) |=> $stable(sda_oe_reg))
    else $error("sda changed under high scl while sending");

endmodule : i2cram_top

// *** tb/i2cram_master_model.sv ***
// two-wire bus master model that drives the link for the bench
`timescale 1ns/1ns
module i2cram_master_model (
  input  wire logic clk_sys,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_m
);
  int glitches;

  // both lines rest high before the first frame
  initial begin
    scl      = 1'b1;
    sda_m    = 1'b1;
    glitches = 0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wait_clk

  // one bit of 320 ns with scl high for 160 ns; sda moves only mid-low
  task automatic bit_io(input logic b, output logic r);
    logic early;
    wait_clk(2);
    sda_m = b;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(2);
    early = sda_w;
    wait_clk(2);
    r = sda_w;
    if (early !== r) glitches++;
    scl = 1'b0;
  endtask : bit_io

  // also serves as repeated start; scl stands still once high
  task automatic start_cond();
    wait_clk(2);
    sda_m = 1'b1;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_m = 1'b0;
    wait_clk(4);
    scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    wait_clk(2);
    sda_m = 1'b0;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_m = 1'b1;
    wait_clk(4);
  endtask : stop_cond

  // released ninth bit lets the receiver answer
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send_byte

  // no acknowledge on the last byte wanted ends the read
  task automatic get_byte(input logic give_ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~give_ack, r);
  endtask : get_byte
endmodule : i2cram_master_model

// *** tb/i2cram_tb_top.sv ***
// self-checking bench for the serial ram slave
`timescale 1ns/1ns
module i2cram_tb_top;
  localparam logic [3:0] UPPER = i2cram_pkg::ADDR_UPPER_DEF;
  localparam int         LIMIT = 30000;
  logic       clk_sys;
  logic       reset_n;
  logic       power_save;
  logic [2:0] pins;
  logic       sda_out;
  logic       sda_oe;
  logic       ack;
  logic       bit_seen;
  logic [7:0] d;
  wire        scl;
  wire        sda_m;
  wire        sda_w;
  int         fails;
  int         n_checks;
  int         cycles;

  // open drain wire with pull-up: low if either side pulls
  assign sda_w = sda_m & ~sda_oe;

  i2cram_top dut (
    .clk_sys          (clk_sys),
    .reset_n          (reset_n),
    .scl_in           (scl),
    .sda_in           (sda_w),
    .sda_out          (sda_out),
    .sda_oe           (sda_oe),
    .hw_addr_bit_zero (pins[0]),
    .hw_addr_bit_one  (pins[1]),
    .hw_addr_bit_two  (pins[2]),
    .power_save       (power_save)
  );

  i2cram_master_model m (
    .clk_sys (clk_sys),
    .sda_w   (sda_w),
    .scl     (scl),
    .sda_m   (sda_m)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // a hung handshake would otherwise stall the run forever
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  function automatic logic [7:0] sla(input logic [2:0] p, input logic rw);
    return {UPPER, p, rw};
  endfunction : sla

  // select this device for writing and load the word pointer
  task automatic set_ptr(input logic [7:0] a);
    m.start_cond();
    m.send_byte(sla(pins, 1'b0), ack);
    chk("address ack", 8'h01, ack);
    m.send_byte(a, ack);
    chk("word ack", 8'h01, ack);
  endtask : set_ptr

  task automatic read_start();
    m.start_cond();
    m.send_byte(sla(pins, 1'b1), ack);
    chk("read address ack", 8'h01, ack);
  endtask : read_start

  // burst across the top of the array, read back, then resume
  task automatic test_write_wrap();
    logic [7:0] wd [4];
    wd = '{8'ha5, 8'h3c, 8'h0f, 8'hc3};
    set_ptr(8'hfe);
    for (int i = 0; i < 4; i++) begin
      m.send_byte(wd[i], ack);
      chk("data ack", 8'h01, ack);
    end
    m.stop_cond();
    set_ptr(8'hfe);
    read_start();
    for (int i = 0; i < 3; i++) begin
      m.get_byte(i < 2, d);
      chk("read data", wd[i], d);
    end
    m.stop_cond();
    chk("sda released", 8'h00, sda_oe);
    read_start();
    m.get_byte(1'b0, d);
    chk("resumed read", wd[3], d);
    m.stop_cond();
    $display("done write_wrap");
  endtask : test_write_wrap

  // every pin code answers its own address and refuses the one with pin bits two and one flipped
  task automatic test_addr_match();
    for (int p = 0; p < 8; p++) begin
      pins = 3'(p);
      m.start_cond();
      m.send_byte(sla(3'(p), 1'b0), ack);
      chk("own address", 8'h01, ack);
      m.start_cond();
      m.send_byte(sla(3'(p) ^ 3'h6, 1'b0), ack);
      chk("foreign address", 8'h00, ack);
      m.send_byte(8'h00, ack);
      chk("ignored byte", 8'h00, ack);
      m.stop_cond();
    end
    pins = 3'h5;
    $display("done addr_match");
  endtask : test_addr_match

  task automatic test_power_save();
    power_save = 1'b1;
    m.start_cond();
    m.send_byte(sla(pins, 1'b0), ack);
    chk("saving ack", 8'h00, ack);
    m.stop_cond();
    power_save = 1'b0;
    m.start_cond();
    m.send_byte(sla(pins, 1'b0), ack);
    chk("woken ack", 8'h01, ack);
    m.stop_cond();
    $display("done power_save");
  endtask : test_power_save

  // a byte cut short by stop must neither store nor step
  task automatic test_partial();
    set_ptr(8'h20);
    m.send_byte(8'h77, ack);
    chk("data ack", 8'h01, ack);
    m.stop_cond();
    set_ptr(8'h20);
    for (int i = 0; i < 4; i++) m.bit_io(1'b0, bit_seen);
    m.stop_cond();
    read_start();
    m.get_byte(1'b0, d);
    chk("partial discarded", 8'h77, d);
    m.stop_cond();
    $display("done partial");
  endtask : test_partial

  // reset in mid-read frees sda at once and rewinds the word address
  task automatic test_mid_reset();
    set_ptr(i2cram_pkg::WORD_ADDR_RST);
    m.send_byte(8'h5a, ack);
    chk("data ack", 8'h01, ack);
    m.stop_cond();
    set_ptr(i2cram_pkg::WORD_ADDR_RST);
    read_start();
    m.wait_clk(4);
    chk("read drive", 8'h01, sda_oe);
    reset_n = 1'b0;
    m.wait_clk(1);
    chk("reset release", 8'h00, sda_oe);
    m.wait_clk(2);
    reset_n = 1'b1;
    m.stop_cond();
    read_start();
    m.get_byte(1'b0, d);
    chk("reset address", 8'h5a, d);
    m.stop_cond();
    $display("done mid_reset");
  endtask : test_mid_reset

  initial begin
    fails      = 0;
    n_checks   = 0;
    cycles     = 0;
    reset_n    = 1'b0;
    power_save = 1'b0;
    pins       = 3'h5;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("idle release", 8'h00, sda_oe);
    chk("sda out", 8'h00, sda_out);
    test_write_wrap();
    test_addr_match();
    test_power_save();
    test_partial();
    test_mid_reset();
    chk("sda steady", 8'h00, 8'(m.glitches));
    give_verdict();
  end
endmodule : i2cram_tb_top
